// [urxes_fifo.sv]
// Flip-flop queue with occupancy count; depth must be a power of two
module urxes_fifo #(
  parameter int unsigned W = 12,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic push, // Store din
  input wire logic [W-1:0] din, // Data in
  input wire logic pop, // Drop head
  output logic [W-1:0] dout, // Head entry
  output logic [$clog2(DEPTH+1)-1:0] count // Entries held
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [CW-1:0] cnt_reg;
  logic do_push;
  logic do_pop;

  assign do_push = push && (cnt_reg != CW'(DEPTH));
  assign do_pop = pop && (cnt_reg != '0);
  assign dout = mem_reg[rp_reg];
  assign count = cnt_reg;

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem_reg[wp_reg] <= din;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule

// [urxes_line_model.sv]
// Remote serial station: drives the block's receive line and captures its transmit line
module urxes_line_model #(
  parameter int BIT = 8 // Clocks per bit
) (
  input wire logic clk_sys, // System clock
  output logic rxd, // Line into the block
  input wire logic txd // Line out of the block
);
  timeunit 1ns;
  timeprecision 1ns;

  initial rxd = 1'b1;

  // Hold a level for a whole number of bit times
  task automatic hold(input logic lvl, input int nbits);
    @(posedge clk_sys);
    rxd <= lvl;
    repeat (nbits * BIT - 1) @(posedge clk_sys);
  endtask

  // One frame, LSB first; stop level is a knob so framing faults can be made
  task automatic send(input logic [7:0] d, input logic pen, input logic pb, input logic stp);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold(d[i], 1);
    end
    if (pen) begin
      hold(pb, 1);
    end
    hold(stp, 1);
    hold(1'b1, 2);
  endtask

  // Line held low well past one frame, then back to mark
  task automatic send_break(input int nbits);
    hold(1'b0, nbits);
    hold(1'b1, 2);
  endtask

  // Sample each data bit in its middle
  task automatic recv(output logic [7:0] d);
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_sys);
      d[i] = txd;
    end
    repeat (BIT) @(posedge clk_sys);
  endtask
endmodule

// [urxes_pkg.sv]
// Package: constants, types and helpers of the serial data and error block
// Function
// - Data write queues byte; read returns oldest
// - Bit 11 flags character lost to overrun
// - Bit 10 flags line low beyond frame
// - Break stores exactly one zero character
// - After break, wait for mark then start
// - Bit 9 flags parity mismatch per line control
// - Bit 8 flags stop bit not one
// - Error flags travel with their queued character
// - Status read shows last data-read entry flags
// - Status layout; overrun shows at once
// - Any status-offset write clears all error flags
// - Overrun keeps queue intact, drops new character
// - Status read-only, resets to zero
// - Entry holds byte plus four status bits
// - Data write starts sending; single holding register
package urxes_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BAUD_HZ = 115_200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD_HZ;
  localparam logic [15:0] BAUD_RST = 16'(BIT_CYC);
  localparam logic [15:0] TICK_AT = 16'h0001;
  localparam int unsigned RXQ_DEPTH = 16;
  localparam int unsigned TXQ_DEPTH = 16;
  localparam logic [2:0] DATA_LAST = 3'h7;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] FRAME_BITS_PAR = 4'hB;

  localparam logic [11:0] OFF_DATA = 12'h000;
  localparam logic [11:0] OFF_RSR = 12'h004;
  localparam logic [11:0] OFF_FLAG = 12'h018;
  localparam logic [11:0] OFF_BAUD = 12'h024;
  localparam logic [11:0] OFF_LCR = 12'h02C;
  localparam logic [11:0] OFF_IM = 12'h038;
  localparam logic [11:0] OFF_RIS = 12'h03C;
  localparam logic [11:0] OFF_MIS = 12'h040;

  localparam int unsigned RS_FRAMING = 0;
  localparam int unsigned RS_PARITY = 1;
  localparam int unsigned RS_BREAK = 2;
  localparam int unsigned RS_OE = 3;
  localparam int unsigned IS_RX = 4;
  localparam int unsigned IS_TX = 5;
  localparam int unsigned LCR_PEN = 1;
  localparam int unsigned LCR_EPS = 2;
  localparam int unsigned LCR_FEN = 4;
  localparam int unsigned LCR_SPS = 7;
  localparam int unsigned FL_BUSY = 3;
  localparam int unsigned FL_RXFE = 4;
  localparam int unsigned FL_TXFF = 5;
  localparam int unsigned FL_RXFF = 6;
  localparam int unsigned FL_TXFE = 7;

  localparam logic [3:0] RSR_RST = 4'h0;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [5:0] IRQ_RST = 6'h00;

  typedef struct packed {
    logic oe;
    logic break_flag;
    logic parity_mismatch_flag;
    logic framing_flag;
    logic [7:0] data;
  } urxes_entry_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } urxes_req_t;

  // Parity bit that the line control asks for
  function automatic logic urxes_par(input logic [7:0] d, input logic eps, input logic sps);
    urxes_par = sps ? ~eps : (eps ? ^d : ~^d);
  endfunction
endpackage

// [urxes_top.sv]
// Serial port data path: receiver, error status, transmit queue and registers
//
// Chosen here: the plain strobed port.
module urxes_top #(
  parameter int unsigned RXQ_DEPTH = urxes_pkg::RXQ_DEPTH, // Receive queue entries
  parameter int unsigned TXQ_DEPTH = urxes_pkg::TXQ_DEPTH // Transmit queue entries
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire urxes_pkg::urxes_req_t bus_req, // Register request
  output logic [31:0] bus_rdata, // Read data, cycle after read
  input wire logic rxd_pin, // Serial receive line
  output logic txd_pin, // Serial transmit line
  output logic irq // Level interrupt
);
  localparam int unsigned RCW = $clog2(RXQ_DEPTH + 1);
  localparam int unsigned TCW = $clog2(TXQ_DEPTH + 1);

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP,
    RX_BRK
  } urxes_rx_st_t;

  logic rxd_m_reg;
  logic rxd_s_reg;
  urxes_rx_st_t st_reg;
  logic [15:0] cnt_reg;
  logic [2:0] idx_reg;
  logic [7:0] sh_reg;
  logic par_reg;
  logic oe_pend_reg;
  logic [3:0] rsr_reg;
  logic [7:0] lcr_reg;
  logic [15:0] baud_reg;
  logic [5:0] im_reg;
  logic [5:0] ris_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] flags;
  logic [5:0] ev;
  urxes_pkg::urxes_entry_t rx_entry;
  urxes_pkg::urxes_entry_t rx_head;
  logic [RCW-1:0] rx_cnt;
  logic [TCW-1:0] tx_cnt;
  logic [7:0] tx_head;
  logic tx_ready;
  logic tx_done;
  logic tx_valid;
  logic bit_tick;
  logic rx_done;
  logic rx_push;
  logic rx_pop;
  logic rxq_full;
  logic txq_full;
  logic ovr_evt;
  logic fen;
  logic pen;
  logic eps;
  logic sps;
  logic wr_dr;
  logic rd_dr;
  logic wr_ecr;
  logic wr_lcr;
  logic wr_baud;
  logic wr_im;
  logic wr_ris;

  // Register decode
  assign wr_dr = bus_req.wr && (bus_req.addr == urxes_pkg::OFF_DATA);
  assign rd_dr = bus_req.rd && (bus_req.addr == urxes_pkg::OFF_DATA);
  assign wr_ecr = bus_req.wr && (bus_req.addr == urxes_pkg::OFF_RSR);
  assign wr_lcr = bus_req.wr && (bus_req.addr == urxes_pkg::OFF_LCR);
  assign wr_baud = bus_req.wr && (bus_req.addr == urxes_pkg::OFF_BAUD);
  assign wr_im = bus_req.wr && (bus_req.addr == urxes_pkg::OFF_IM);
  assign wr_ris = bus_req.wr && (bus_req.addr == urxes_pkg::OFF_RIS);

  assign fen = lcr_reg[urxes_pkg::LCR_FEN];
  assign pen = lcr_reg[urxes_pkg::LCR_PEN];
  assign eps = lcr_reg[urxes_pkg::LCR_EPS];
  assign sps = lcr_reg[urxes_pkg::LCR_SPS];

  // Receive line synchroniser
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxd_m_reg <= 1'b1;
      rxd_s_reg <= 1'b1;
    end else begin
      rxd_m_reg <= rxd_pin;
      rxd_s_reg <= rxd_m_reg;
    end
  end

  assign bit_tick = cnt_reg <= urxes_pkg::TICK_AT;
  assign rx_done = (st_reg == RX_STOP) && bit_tick;

  // Receive framing: sample mid-bit, least significant bit first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= RX_IDLE;
      cnt_reg <= '0;
      idx_reg <= '0;
      sh_reg <= '0;
      par_reg <= 1'b0;
    end else begin
      if (!bit_tick) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      case (st_reg)
        RX_IDLE: begin
          if (!rxd_s_reg) begin
            st_reg <= RX_START;
            cnt_reg <= baud_reg >> 1;
          end
        end
        RX_START: begin
          if (bit_tick) begin
            cnt_reg <= baud_reg;
            idx_reg <= '0;
            st_reg <= rxd_s_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bit_tick) begin
            sh_reg <= {rxd_s_reg, sh_reg[7:1]};
            idx_reg <= idx_reg + 3'h1;
            cnt_reg <= baud_reg;
            if (idx_reg == urxes_pkg::DATA_LAST) begin
              st_reg <= pen ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (bit_tick) begin
            par_reg <= rxd_s_reg;
            cnt_reg <= baud_reg;
            st_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (bit_tick) begin
            st_reg <= rx_entry.break_flag ? RX_BRK : RX_IDLE;
          end
        end
        RX_BRK: begin
          if (rxd_s_reg) begin
            st_reg <= RX_IDLE;
          end
        end
        default: begin
          st_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // Entry built at the stop bit; flags travel with the byte
  always_comb begin
    rx_entry.data = sh_reg;
    rx_entry.framing_flag = !rxd_s_reg;
    rx_entry.parity_mismatch_flag = pen && (par_reg != urxes_pkg::urxes_par(sh_reg, eps, sps));
    rx_entry.break_flag = !rxd_s_reg && (sh_reg == '0) && (!pen || !par_reg);
    rx_entry.oe = oe_pend_reg;
  end

  // Without queueing the storage is one holding entry
  assign rxq_full = fen ? (rx_cnt == RCW'(RXQ_DEPTH)) : (rx_cnt != '0);
  assign rx_push = rx_done && !rxq_full;
  assign ovr_evt = rx_done && rxq_full;
  assign rx_pop = rd_dr && (rx_cnt != '0);

  urxes_fifo #(
    .W($bits(urxes_pkg::urxes_entry_t)),
    .DEPTH(RXQ_DEPTH)
  ) u_rxq (
    .clk_sys(clk_sys),
    .rst(rst),
    .push(rx_push),
    .din(rx_entry),
    .pop(rx_pop),
    .dout(rx_head),
    .count(rx_cnt)
  );

  // Lost character marked on the next one stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oe_pend_reg <= 1'b0;
    end else if (ovr_evt) begin
      oe_pend_reg <= 1'b1;
    end else if (rx_push) begin
      oe_pend_reg <= 1'b0;
    end
  end

  // Receive status: latched on data read, overrun at once, any write clears
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsr_reg <= urxes_pkg::RSR_RST;
    end else begin
      if (wr_ecr) begin
        rsr_reg <= urxes_pkg::RSR_RST;
      end else if (rx_pop) begin
        rsr_reg[urxes_pkg::RS_FRAMING] <= rx_head.framing_flag;
        rsr_reg[urxes_pkg::RS_PARITY] <= rx_head.parity_mismatch_flag;
        rsr_reg[urxes_pkg::RS_BREAK] <= rx_head.break_flag;
        rsr_reg[urxes_pkg::RS_OE] <= rsr_reg[urxes_pkg::RS_OE] | rx_head.oe;
      end
      if (ovr_evt) begin
        rsr_reg[urxes_pkg::RS_OE] <= 1'b1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lcr_reg <= urxes_pkg::LCR_RST;
      baud_reg <= urxes_pkg::BAUD_RST;
      im_reg <= urxes_pkg::IRQ_RST;
    end else begin
      if (wr_lcr) begin
        lcr_reg <= bus_req.wdata[7:0];
      end
      if (wr_baud) begin
        baud_reg <= bus_req.wdata[15:0];
      end
      if (wr_im) begin
        im_reg <= bus_req.wdata[5:0];
      end
    end
  end

  // Interrupt events
  always_comb begin
    ev = '0;
    ev[urxes_pkg::RS_FRAMING] = rx_push && rx_entry.framing_flag;
    ev[urxes_pkg::RS_PARITY] = rx_push && rx_entry.parity_mismatch_flag;
    ev[urxes_pkg::RS_BREAK] = rx_push && rx_entry.break_flag;
    ev[urxes_pkg::RS_OE] = ovr_evt;
    ev[urxes_pkg::IS_RX] = rx_push;
    ev[urxes_pkg::IS_TX] = tx_done;
  end

  // Write one to clear; a new event wins over its clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ris_reg <= urxes_pkg::IRQ_RST;
    end else begin
      ris_reg <= (ris_reg & ~(wr_ris ? bus_req.wdata[5:0] : 6'h00)) | ev;
    end
  end

  assign irq = |(ris_reg & im_reg);

  // Transmit path
  assign txq_full = fen ? (tx_cnt == TCW'(TXQ_DEPTH)) : (tx_cnt != '0);
  assign tx_valid = tx_cnt != '0;

  urxes_fifo #(
    .W(8),
    .DEPTH(TXQ_DEPTH)
  ) u_txq (
    .clk_sys(clk_sys),
    .rst(rst),
    .push(wr_dr && !txq_full),
    .din(bus_req.wdata[7:0]),
    .pop(tx_valid && tx_ready),
    .dout(tx_head),
    .count(tx_cnt)
  );

  urxes_tx u_tx (
    .clk_sys(clk_sys),
    .rst(rst),
    .period(baud_reg),
    .pen(pen),
    .par(urxes_pkg::urxes_par(tx_head, eps, sps)),
    .data(tx_head),
    .valid(tx_valid),
    .ready(tx_ready),
    .txd(txd_pin),
    .done(tx_done)
  );

  // Status flags
  always_comb begin
    flags = '0;
    flags[urxes_pkg::FL_BUSY] = tx_valid || !tx_ready;
    flags[urxes_pkg::FL_RXFE] = rx_cnt == '0;
    flags[urxes_pkg::FL_TXFF] = txq_full;
    flags[urxes_pkg::FL_RXFF] = rxq_full;
    flags[urxes_pkg::FL_TXFE] = tx_cnt == '0;
  end

  // Read multiplexer
  always_comb begin
    rdata_next = '0;
    case (bus_req.addr)
      urxes_pkg::OFF_DATA: begin
        rdata_next = (rx_cnt != '0) ? 32'(rx_head) : '0;
      end
      urxes_pkg::OFF_RSR: begin
        rdata_next = 32'(rsr_reg);
      end
      urxes_pkg::OFF_FLAG: begin
        rdata_next = 32'(flags);
      end
      urxes_pkg::OFF_BAUD: begin
        rdata_next = 32'(baud_reg);
      end
      urxes_pkg::OFF_LCR: begin
        rdata_next = 32'(lcr_reg);
      end
      urxes_pkg::OFF_IM: begin
        rdata_next = 32'(im_reg);
      end
      urxes_pkg::OFF_RIS: begin
        rdata_next = 32'(ris_reg);
      end
      urxes_pkg::OFF_MIS: begin
        rdata_next = 32'(ris_reg & im_reg);
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= bus_req.rd ? rdata_next : '0;
    end
  end

  assign bus_rdata = rdata_reg;

  a_rd_head_entry:
  assert property (@(posedge clk_sys) disable iff (rst)
    rx_pop |=> bus_rdata[11:0] == $past(rx_head))
    else $error("data read did not return the queue head");

  a_oe_pend_hold:
  assert property (@(posedge clk_sys) disable iff (rst)
    (ovr_evt || (oe_pend_reg && !rx_push)) |=> oe_pend_reg)
    else $error("lost character mark dropped before next store");

  a_brk_enter_wait:
  assert property (@(posedge clk_sys) disable iff (rst)
    (rx_done && rx_entry.break_flag) |=> st_reg == RX_BRK)
    else $error("break not followed by wait for mark");

  a_brk_zero_char:
  assert property (@(posedge clk_sys) disable iff (rst)
    (rx_push && rx_entry.break_flag) |-> (rx_entry.data == '0) && rx_entry.framing_flag)
    else $error("break stored a nonzero character");

  a_brk_no_store:
  assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg == RX_BRK) |-> !rx_push && !ovr_evt)
    else $error("character stored during break");

  a_brk_need_mark:
  assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg == RX_BRK && !rxd_s_reg) |=> st_reg == RX_BRK)
    else $error("break left while line low");

  a_rsr_latch_flags:
  assert property (@(posedge clk_sys) disable iff (rst)
    rx_pop |=> rsr_reg[2:0] == {$past(rx_head.break_flag), $past(rx_head.parity_mismatch_flag),
      $past(rx_head.framing_flag)})
    else $error("status does not match entry just read");

  a_ovr_status_now:
  assert property (@(posedge clk_sys) disable iff (rst)
    ovr_evt |=> rsr_reg[urxes_pkg::RS_OE] && ris_reg[urxes_pkg::RS_OE])
    else $error("overrun not shown in the next cycle");

  a_ecr_clears_all:
  assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ecr && !ovr_evt) |=> rsr_reg == '0)
    else $error("error clear write left a flag set");

  a_ovr_queue_kept:
  assert property (@(posedge clk_sys) disable iff (rst)
    (ovr_evt && !rx_pop) |=> rx_cnt == $past(rx_cnt))
    else $error("queue changed on overrun");

  a_read_pops_one:
  assert property (@(posedge clk_sys) disable iff (rst)
    (rx_pop && !rx_push) |=> rx_cnt == $past(rx_cnt) - RCW'(1))
    else $error("data read did not remove one entry");
endmodule

// [urxes_top_bench.sv]
// Self-checking bench for the serial data and receive error path
module urxes_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BIT = 8;
  localparam int QD = 4;
  localparam logic [11:0] A_DAT = urxes_pkg::OFF_DATA;
  localparam logic [11:0] A_RSR = urxes_pkg::OFF_RSR;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  urxes_pkg::urxes_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  logic rxd_pin;
  logic txd_pin;
  logic irq;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rd_val;
  logic [7:0] tx_got;
  logic [7:0] lc;
  logic [7:0] d;
  logic p;
  logic [7:0] modes [4] = '{8'h02, 8'h06, 8'h82, 8'h86};

  always #25 clk_sys = ~clk_sys;

  urxes_top #(.RXQ_DEPTH(QD), .TXQ_DEPTH(4)) i_urxes_top (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .irq(irq));
  urxes_line_model #(.BIT(BIT)) i_urxes_line_model (.clk_sys(clk_sys), .rxd(rxd_pin), .txd(txd_pin));

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe; taken at the edge closing it
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(posedge clk_sys);
    v = bus_rdata;
  endtask

  task automatic expect_rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus_rd(a, rd_val);
    chk(rd_val, exp, what);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    chk({31'h0, irq}, 32'h0000_0000, "irq after reset");
    expect_rd(A_RSR, 32'h0000_0000, "status reset");
    expect_rd(urxes_pkg::OFF_FLAG, 32'h0000_0090, "flags after reset");
    expect_rd(A_DAT, 32'h0000_0000, "empty data read");
    expect_rd(12'h100, 32'h0000_0000, "unmapped read");
    bus_wr(urxes_pkg::OFF_BAUD, 32'h0000_0008);
    bus_wr(urxes_pkg::OFF_LCR, 32'h0000_0000);
    bus_wr(urxes_pkg::OFF_IM, 32'h0000_0001);
    i_urxes_line_model.send(8'hA5, 1'b0, 1'b0, 1'b1);
    expect_rd(A_DAT, 32'h0000_00A5, "clean byte");
    expect_rd(A_DAT, 32'h0000_0000, "entry removed");
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    i_urxes_line_model.send(8'h3C, 1'b0, 1'b0, 1'b0);
    chk({31'h0, irq}, 32'h0000_0001, "irq on framing");
    expect_rd(A_DAT, 32'h0000_013C, "framing flag");
    expect_rd(A_RSR, 32'h0000_0001, "status follows read");
    expect_rd(urxes_pkg::OFF_MIS, 32'h0000_0001, "masked status");
    bus_wr(A_RSR, 32'hFFFF_FFFF);
    expect_rd(A_RSR, 32'h0000_0000, "status cleared");
    bus_wr(urxes_pkg::OFF_RIS, 32'h0000_003F);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    // Each parity mode with a correct and a wrong parity bit
    for (int m = 0; m < 4; m++) begin
      lc = modes[m];
      bus_wr(urxes_pkg::OFF_LCR, {24'h0, lc});
      for (int b = 0; b < 2; b++) begin
        d = 8'h30 + 8'(m * 2 + b);
        p = lc[7] ? ~lc[2] : (lc[2] ? ^d : ~^d);
        i_urxes_line_model.send(d, 1'b1, p ^ b[0], 1'b1);
        expect_rd(A_DAT, {22'h0, b[0], 1'b0, d}, "parity flag");
        expect_rd(A_RSR, {30'h0, b[0], 1'b0}, "status parity");
      end
      bus_wr(A_RSR, 32'h0000_0000);
    end
    bus_wr(urxes_pkg::OFF_LCR, 32'h0000_0000);
    i_urxes_line_model.send_break(30);
    expect_rd(A_DAT, 32'h0000_0500, "break entry");
    expect_rd(A_RSR, 32'h0000_0005, "status break");
    expect_rd(A_DAT, 32'h0000_0000, "single break entry");
    bus_wr(A_RSR, 32'h0000_0000);
    i_urxes_line_model.send(8'h11, 1'b0, 1'b0, 1'b1);
    expect_rd(A_DAT, 32'h0000_0011, "byte after break");
    // Holding register full: second byte is lost
    i_urxes_line_model.send(8'h21, 1'b0, 1'b0, 1'b1);
    i_urxes_line_model.send(8'h22, 1'b0, 1'b0, 1'b1);
    expect_rd(A_RSR, 32'h0000_0008, "overrun at once");
    expect_rd(A_DAT, 32'h0000_0021, "held byte kept");
    i_urxes_line_model.send(8'h33, 1'b0, 1'b0, 1'b1);
    expect_rd(A_DAT, 32'h0000_0833, "overrun marked");
    bus_wr(A_RSR, 32'h0000_0000);
    expect_rd(A_RSR, 32'h0000_0000, "overrun cleared");
    // Queue enabled: one extra frame beyond depth, one framing fault inside
    bus_wr(urxes_pkg::OFF_LCR, 32'h0000_0010);
    for (int k = 0; k <= QD; k++) begin
      i_urxes_line_model.send(8'h40 + 8'(k), 1'b0, 1'b0, k != 2);
    end
    for (int k = 0; k < QD; k++) begin
      expect_rd(A_DAT, {23'h0, k == 2, 8'h40 + 8'(k)}, "queued entry");
    end
    expect_rd(A_RSR, 32'h0000_0008, "queue overrun");
    expect_rd(A_DAT, 32'h0000_0000, "lost frame not stored");
    bus_wr(A_RSR, 32'h0000_0000);
    bus_wr(urxes_pkg::OFF_LCR, 32'h0000_0000);
    fork
      i_urxes_line_model.recv(tx_got);
      bus_wr(A_DAT, 32'h0000_005A);
    join
    chk({24'h0, tx_got}, 32'h0000_005A, "sent byte");
    give_verdict();
  end
endmodule

// [urxes_tx.sv]
// Serial transmitter: start, eight data bits, optional parity, one stop
module urxes_tx (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [15:0] period, // Clocks per bit
  input wire logic pen, // Parity enable
  input wire logic par, // Parity bit to send
  input wire logic [7:0] data, // Byte to send
  input wire logic valid, // Byte offered
  output logic ready, // Shifter idle
  output logic txd, // Serial line
  output logic done // Last bit finished
);
  logic [10:0] sh_reg;
  logic [3:0] nb_reg;
  logic [15:0] cnt_reg;
  logic accept;
  logic tick;

  assign ready = nb_reg == '0;
  assign accept = valid && ready;
  assign tick = cnt_reg <= urxes_pkg::TICK_AT;
  assign done = (nb_reg == 4'h1) && tick;
  assign txd = sh_reg[0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sh_reg <= '1;
      nb_reg <= '0;
      cnt_reg <= '0;
    end else if (accept) begin
      sh_reg <= pen ? {1'b1, par, data, 1'b0} : {2'b11, data, 1'b0};
      nb_reg <= pen ? urxes_pkg::FRAME_BITS_PAR : urxes_pkg::FRAME_BITS;
      cnt_reg <= period;
    end else if (nb_reg != '0) begin
      if (tick) begin
        sh_reg <= {1'b1, sh_reg[10:1]};
        nb_reg <= nb_reg - 4'h1;
        cnt_reg <= period;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  a_tx_start_bit:
  assert property (@(posedge clk_sys) disable iff (rst) accept |=> !txd && !ready)
    else $error("transmit did not start with a start bit");
endmodule
